// ===== core/scan_instr_unit.sv
// Boundary-scan instruction unit: test-port state machine, instruction register,
// identification, bypass and boundary chain, and the pin-control handover.
// Assumes tms_i/tdi_i are launched by the tester on the falling edge of tck_i,
// and that resetn_i is the power-up reset seen by both clock domains.
`timescale 1ns/100ps

module scan_instr_unit
    import scan_pkg::*;
#(
    parameter int BSR_W = 16,
    parameter logic [BSR_W-1:0] PIN_MASK = {BSR_W{1'b1}},
    parameter logic [ID_W-1:0] IDENTIFICATION_ROM = 32'h0000_5A5B // arbitrary value, bit 0 set
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    input wire logic [BSR_W-1:0] pins_i,
    output logic [BSR_W-1:0] test_data_o,
    output logic test_drive_o,
    output logic out_float_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // standard test-port state transitions
    function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
        tap_state_t n;
        n = ST_RESET;
        case (s)
            ST_RESET: n = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAPTURE_DR;
            ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_UPDATE_DR: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = tms ? ST_RESET : ST_CAPTURE_IR;
            ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
            ST_UPDATE_IR: n = tms ? ST_SEL_DR : ST_IDLE;
            default: n = ST_RESET;
        endcase
        return n;
    endfunction

    // instruction decode; every unlisted code falls back to bypass
    function automatic ctrl_t decode(input logic [IR_W-1:0] ir);
        ctrl_t c;
        c = '{path: PATH_BYPASS, drive: 1'b0, float_out: 1'b0};
        if (ir == INS_EXTEST) begin
            c = '{path: PATH_CHAIN, drive: 1'b1, float_out: 1'b0};
        end else if (ir == INS_IDCODE) begin
            c.path = PATH_ID;
        end else if (ir == INS_SAMPLE_Z) begin
            c = '{path: PATH_CHAIN, drive: 1'b0, float_out: 1'b1};
        end else if (ir == INS_SAMPLE) begin
            c.path = PATH_CHAIN;
        end else begin
            c.path = PATH_BYPASS;
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // rising-edge test-clock state

    typedef struct packed {
        tap_state_t st;
        logic [IR_W-1:0] ir_sh;
        logic [ID_W-1:0] id_sh;
        logic [BSR_W-1:0] bsr_sh;
        logic byp;
        logic [BSR_W-1:0] pin_s1;
        logic [BSR_W-1:0] pin_s2;
    } pos_t;

    // falling-edge test-clock state
    typedef struct packed {
        logic [IR_W-1:0] ir;
        ctrl_t ctrl;
        logic [BSR_W-1:0] upd;
        logic upd_tgl;
        logic tdo;
        logic tdo_oe_n;
    } neg_t;

    // memory-clock side of the crossing
    typedef struct packed {
        logic [2:0] tgl_s;
        logic [1:0] drv_s;
        logic [1:0] flt_s;
        logic [BSR_W-1:0] data;
        logic drive;
        logic float_out;
    } mc_t;

    pos_t p_q, p_d;
    neg_t n_q, n_d;
    mc_t m_q, m_d;

    ////////////////////////////////////////////////////////////////////////////////
    // rising edge: state advance, capture and shift

    always_comb begin
        p_d = p_q;
        p_d.st = tap_next(p_q.st, tms_i);
        // pins come from another domain, so two flops before the capture reads them
        p_d.pin_s1 = pins_i;
        p_d.pin_s2 = p_q.pin_s1;
        case (p_q.st)
            ST_CAPTURE_IR: begin
                p_d.ir_sh = CAPTURE_IR_VAL;
            end
            ST_SHIFT_IR: begin
                p_d.ir_sh = {tdi_i, p_q.ir_sh[IR_W-1:1]};
            end
            ST_CAPTURE_DR: begin
                p_d.byp = 1'b0;
                if (n_q.ctrl.path == PATH_ID) begin
                    p_d.id_sh = IDENTIFICATION_ROM;
                end
                if (n_q.ctrl.path == PATH_CHAIN) begin
                    p_d.bsr_sh = (p_q.pin_s2 & PIN_MASK) | ~PIN_MASK;
                end
            end
            ST_SHIFT_DR: begin
                case (n_q.ctrl.path)
                    PATH_ID: p_d.id_sh = {tdi_i, p_q.id_sh[ID_W-1:1]};
                    PATH_CHAIN: p_d.bsr_sh = {tdi_i, p_q.bsr_sh[BSR_W-1:1]};
                    default: p_d.byp = tdi_i;
                endcase
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge tck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p_q <= '{st: ST_RESET, ir_sh: '0, id_sh: '0, bsr_sh: '0, byp: 1'b0,
                     pin_s1: '0, pin_s2: '0};
        end else begin
            p_q <= p_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // falling edge: instruction update, chain update and serial output

    always_comb begin
        n_d = n_q;
        n_d.tdo_oe_n = 1'b1;
        if (p_q.st == ST_RESET) begin
            n_d.ir = INS_IDCODE;
            n_d.ctrl = decode(INS_IDCODE);
        end else if (p_q.st == ST_UPDATE_IR) begin
            // new instruction takes effect only here or at Test-Logic-Reset, shifted bits never leak early
            n_d.ir = p_q.ir_sh;
            n_d.ctrl = decode(p_q.ir_sh);
        end
        if (p_q.st == ST_UPDATE_DR && n_q.ctrl.path == PATH_CHAIN) begin
            n_d.upd = p_q.bsr_sh;
            n_d.upd_tgl = ~n_q.upd_tgl;
        end
        if (p_q.st == ST_SHIFT_IR) begin
            n_d.tdo = p_q.ir_sh[0];
            n_d.tdo_oe_n = 1'b0;
        end else if (p_q.st == ST_SHIFT_DR) begin
            n_d.tdo_oe_n = 1'b0;
            case (n_q.ctrl.path)
                PATH_ID: n_d.tdo = p_q.id_sh[0];
                PATH_CHAIN: n_d.tdo = p_q.bsr_sh[0];
                default: n_d.tdo = p_q.byp;
            endcase
        end
    end

    always_ff @(negedge tck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            n_q <= '{ir: INS_IDCODE, ctrl: '{path: PATH_ID, drive: 1'b0, float_out: 1'b0},
                     upd: '0, upd_tgl: 1'b0, tdo: 1'b0, tdo_oe_n: 1'b1};
        end else begin
            n_q <= n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // memory-clock side: levels through three flops, chain word by toggle handshake

    always_comb begin
        m_d = m_q;
        m_d.tgl_s = {m_q.tgl_s[1:0], n_q.upd_tgl};
        m_d.drv_s = {m_q.drv_s[0], n_q.ctrl.drive};
        m_d.flt_s = {m_q.flt_s[0], n_q.ctrl.float_out};
        m_d.drive = m_q.drv_s[1];
        m_d.float_out = m_q.flt_s[1];
        // the update word is held still between toggles, so sampling it here is safe
        if (m_q.tgl_s[2] != m_q.tgl_s[1]) begin
            m_d.data = n_q.upd;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

    assign tdo_o = n_q.tdo;
    assign tdo_oe_n_o = n_q.tdo_oe_n;
    assign test_data_o = m_q.data;
    assign test_drive_o = m_q.drive;
    assign out_float_o = m_q.float_out;

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the test-clock side and on the memory-clock crossing

    sequence s_update_ir;
        p_q.st == ST_UPDATE_IR;
    endsequence

    sequence s_capture_dr;
        p_q.st == ST_CAPTURE_DR;
    endsequence

    chk_extest_path_decode: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        s_update_ir and p_q.ir_sh == 3'h0 |=> n_q.ctrl.path == PATH_CHAIN && n_q.ctrl.drive)
        else $error("code 000 did not select external test");

    chk_id_capture_rom: assert property (
        @(posedge tck_i) disable iff (!resetn_i)
        s_capture_dr and n_q.ctrl.path == PATH_ID |=> p_q.id_sh == IDENTIFICATION_ROM)
        else $error("identification register not loaded from rom");

    chk_reset_selects_id: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        p_q.st == ST_RESET |=> n_q.ir == 3'h1)
        else $error("identification not current after reset state");

    chk_sample_z_float: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        s_update_ir and p_q.ir_sh == 3'h2 |=> n_q.ctrl.float_out && !n_q.ctrl.drive)
        else $error("high-impedance sample did not float outputs");

    chk_reserved_bypass: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        s_update_ir and p_q.ir_sh == 3'h3 |=> n_q.ctrl == ctrl_t'{PATH_BYPASS, 1'b0, 1'b0})
        else $error("reserved code did not act as bypass");

    chk_instr_holds_stable: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        p_q.st != ST_UPDATE_IR && p_q.st != ST_RESET |=> $stable(n_q.ir))
        else $error("instruction changed outside Update-IR");

    chk_chain_capture_pins: assert property (
        @(posedge tck_i) disable iff (!resetn_i)
        s_capture_dr and n_q.ctrl.path == PATH_CHAIN
        |=> p_q.bsr_sh == (($past(p_q.pin_s2) & PIN_MASK) | ~PIN_MASK))
        else $error("chain capture does not match pins");

    chk_bypass_shift_delay: assert property (
        @(posedge tck_i) disable iff (!resetn_i)
        p_q.st == ST_SHIFT_DR && n_q.ctrl.path == PATH_BYPASS |=> p_q.byp == $past(tdi_i))
        else $error("bypass bit did not take tdi");

    chk_drive_reaches_pins: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        $rose(n_q.ctrl.drive) |-> ##[1:4] m_q.drive)
        else $error("drive enable did not reach memory side");

    chk_float_reaches_pins: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        $rose(n_q.ctrl.float_out) |-> ##[1:4] m_q.float_out)
        else $error("float enable did not reach memory side");

    // a toggle starts the word handover; three flops plus the load edge bound the wait
    sequence s_update_toggle;
        $changed(n_q.upd_tgl);
    endsequence

    chk_update_word_lands: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        s_update_toggle |-> ##[1:5] (m_q.data == n_q.upd))
        else $error("chain word did not reach memory side");

    sequence s_shift_any;
        p_q.st == ST_SHIFT_DR || p_q.st == ST_SHIFT_IR;
    endsequence

    chk_tdo_enable_shift: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        s_shift_any |=> !n_q.tdo_oe_n)
        else $error("serial output not enabled while shifting");

    chk_capture_ir_load: assert property (
        @(posedge tck_i) disable iff (!resetn_i)
        p_q.st == ST_CAPTURE_IR |=> p_q.ir_sh == CAPTURE_IR_VAL)
        else $error("instruction register capture value wrong");

    chk_id_shift_in: assert property (
        @(posedge tck_i) disable iff (!resetn_i)
        p_q.st == ST_SHIFT_DR && n_q.ctrl.path == PATH_ID
        |=> p_q.id_sh[ID_W-1] == $past(tdi_i))
        else $error("identification register did not take tdi");

    chk_sample_z_chain: assert property (
        @(negedge tck_i) disable iff (!resetn_i)
        s_update_ir and p_q.ir_sh == 3'h2 |=> n_q.ctrl.path == PATH_CHAIN)
        else $error("high-impedance sample did not route the chain");

endmodule

// ===== core/scan_pkg.sv
// Constants, types and carriers of the boundary-scan instruction unit.
// Assumes one test clock from the tester and one memory clock inside the part.
package scan_pkg;

    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam logic [2:0] CAPTURE_IR_VAL = 3'h1;
    localparam logic [3:0] TAP_RESET_VAL = 4'hF;

    typedef enum logic [2:0] {
        INS_EXTEST = 3'h0,
        INS_IDCODE = 3'h1,
        INS_SAMPLE_Z = 3'h2,
        INS_RESERVED = 3'h3,
        INS_SAMPLE = 3'h4,
        INS_BYPASS = 3'h7
    } instr_t;

    typedef enum logic [3:0] {
        ST_EXIT2_DR = 4'h0,
        ST_EXIT1_DR = 4'h1,
        ST_SHIFT_DR = 4'h2,
        ST_PAUSE_DR = 4'h3,
        ST_SEL_IR = 4'h4,
        ST_UPDATE_DR = 4'h5,
        ST_CAPTURE_DR = 4'h6,
        ST_SEL_DR = 4'h7,
        ST_EXIT2_IR = 4'h8,
        ST_EXIT1_IR = 4'h9,
        ST_SHIFT_IR = 4'hA,
        ST_PAUSE_IR = 4'hB,
        ST_IDLE = 4'hC,
        ST_UPDATE_IR = 4'hD,
        ST_CAPTURE_IR = 4'hE,
        ST_RESET = 4'hF
    } tap_state_t;

    typedef enum logic [1:0] {
        PATH_BYPASS = 2'h0,
        PATH_ID = 2'h1,
        PATH_CHAIN = 2'h2
    } path_t;

    // decoded controls that all change together at Update-IR
    typedef struct packed {
        path_t path;
        logic drive;
        logic float_out;
    } ctrl_t;

endpackage

// ===== sim/scan_instr_unit_tb_top.sv
// Self-checking bench of the boundary-scan instruction unit.
// Assumes the tester model owns tck/tms/tdi; the bench owns reset and pin levels.
`timescale 1ns/100ps

`define CHECK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: %s", $time, msg); end end

module scan_instr_unit_tb_top;
    import scan_pkg::*;
    localparam int BW = 8;
    localparam logic [BW-1:0] MASK = 8'h0F;
    localparam logic [ID_W-1:0] ROM = 32'h0000_3C71; // arbitrary value, bit 0 set
    localparam int LIMIT = 20000;
    logic mclk_i = 1'b0;
    logic resetn_i;
    logic tck, tms, tdi, tdo, tdo_oe_n, drive, flt;
    logic [BW-1:0] pins, test_data;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    always #20 mclk_i = ~mclk_i;

    scan_instr_unit #(.BSR_W(BW), .PIN_MASK(MASK), .IDENTIFICATION_ROM(ROM)) dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .pins_i(pins), .test_data_o(test_data),
        .test_drive_o(drive), .out_float_o(flt));

    scan_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
        .tdo_oe_n_i(tdo_oe_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // the pin crossing takes 3-4 mclk; six leaves margin, sampled on the quiet edge
    task automatic settle();
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic load(input logic [2:0] code);
        logic [2:0] c;
        tester.ir_shift(code, c);
        `CHECK(c, 3'h1, "ir capture")
        tester.ir_update();
        settle();
    endtask

    task automatic set_pins(input logic [BW-1:0] v);
        @(posedge mclk_i);
        pins <= v;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        `CHECK({tdo_oe_n, drive, flt, test_data}, 11'h400, "levels after reset")
        // the port wakes in Test-Logic-Reset; one low tms step reaches Idle
        tester.go(8'h00, 1);
        tester.dr_shift(32, 32'h0, d);
        `CHECK(d, ROM, "id at power-up")
        load(3'h7);
        tester.reset_tap();
        tester.dr_shift(32, 32'hFFFF_FFFF, d);
        `CHECK(d, ROM, "id after tap reset")
        load(3'h1);
        tester.dr_shift(32, 32'h0, d);
        `CHECK(d, ROM, "id by code")
        $display("test reset done");
    endtask

    task automatic t_bypass();
        logic [31:0] d;
        logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
        foreach (codes[i]) begin
            load(codes[i]);
            tester.dr_shift(8, 32'hB4, d);
            `CHECK(d[7:1], 7'h34, "one-bit path")
            `CHECK({drive, flt}, 2'b00, "no pin control")
        end
        $display("test bypass done");
    endtask

    task automatic t_sample_z();
        logic [31:0] d;
        set_pins(8'hA5);
        load(3'h2);
        `CHECK({drive, flt}, 2'b01, "outputs float")
        tester.dr_shift(BW, 32'h0, d);
        `CHECK(d[7:0], 8'hF5, "ring capture")
        $display("test sample_z done");
    endtask

    // preload first so the pins come up with a known word
    task automatic t_extest();
        logic [31:0] d;
        logic [2:0] c;
        load(3'h4);
        tester.dr_shift(BW, 32'h3C, d);
        load(3'h0);
        `CHECK({drive, flt}, 2'b10, "extest drives")
        `CHECK(test_data, 8'h3C, "preloaded word")
        set_pins(8'h69);
        tester.dr_shift(BW, 32'hC3, d);
        `CHECK(d[7:0], 8'hF9, "capture pins and pads")
        settle();
        `CHECK(test_data, 8'hC3, "updated word")
        tester.ir_shift(3'h2, c);
        `CHECK(c, 3'h1, "ir capture under extest")
        settle();
        `CHECK({drive, flt}, 2'b10, "held before update")
        tester.ir_update();
        settle();
        `CHECK({drive, flt}, 2'b01, "applied at update")
        $display("test extest done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            final_report();
        end
    end

    // reset with a few tck pulses inside it, then the scenarios
    initial begin
        resetn_i = 1'b0;
        pins = '0;
        fork
            tester.go(8'hFF, 3);
            repeat (10) @(posedge mclk_i);
        join
        resetn_i <= 1'b1;
        @(negedge mclk_i);
        t_reset();
        t_bypass();
        t_sample_z();
        t_extest();
        final_report();
    end
endmodule

// ===== sim/scan_tester.sv
// Behavioural board tester: drives the test clock, mode select and serial data in.
// Assumes the unit samples on rising tck and shifts tdo out on falling tck.
`timescale 1ns/100ps

module scan_tester (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i
);
    // clock rests low between frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one tck period; tdi toggles when not shifting so a stale bit never looks valid
    task automatic step(input logic tms, input logic tdi, input logic sh, output logic tdo);
        tms_o = tms;
        tdi_o = sh ? tdi : ~tdi_o;
        #16 tck_o = 1'b1;
        // a released line reads as the board pull-up, so a missing enable shows up
        tdo = tdo_oe_n_i ? 1'b1 : tdo_i;
        #16 tck_o = 1'b0;
    endtask

    // tms sequence, lsb first, nothing shifted
    task automatic go(input logic [7:0] seq, input int n);
        logic t;
        for (int i = 0; i < n; i++) step(seq[i], 1'b0, 1'b0, t);
    endtask

    // five highs reach Test-Logic-Reset, then rest in Idle
    task automatic reset_tap();
        go(8'h1F, 6);
    endtask

    // Idle to Shift-IR, exactly three bits, then park in Pause-IR
    task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
        go(8'h03, 4);
        for (int i = 0; i < 3; i++) step(i == 2, code[i], 1'b1, cap[i]);
        go(8'h00, 1);
    endtask

    // Exit2-IR, Update-IR, Idle
    task automatic ir_update();
        go(8'h03, 3);
    endtask

    // Idle through Capture-DR and Shift-DR, then Update-DR and back to Idle
    task automatic dr_shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        go(8'h01, 3);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], 1'b1, dout[i]);
        go(8'h01, 2);
    endtask
endmodule
